// *** core/tes_core.sv ***
/*
  Transient (AC) event status and threshold logic with a classic
  Wishbone slave, a one-bit sticky interrupt and its mask.
  Assumes samples arrive already high-pass filtered, one valid pulse
  per output-data-rate period, synchronous to clk_i.
*/
`timescale 1ns/1ps
`include "tes_regs.svh"

// Behaviour
// - The summary active bit is set while any axis flag is set and clear otherwise.
// - An axis flag sets if that axis is over threshold when the shared debounce count is reached; Z, Y, X flags at bits 5, 3, 1.
// - Each polarity bit is zero for a positive excursion and one for a negative one, at bits 4, 2, 0.
// - With latch enable set, flags and polarity freeze once the interrupt event fires.
// - With latch enable clear, later events keep updating flags and polarity.
// - A set flag clears only as a side effect of a host read of the source register.
// - Debounce mode zero decrements the counter in a sample period without the condition.
// - Debounce mode one clears the counter in a sample period without the condition.
// - The shared threshold is 7-bit unsigned at 62.5 mg (64 counts) per step on the 8 g scale, whatever the range.
// - The low-noise bit forces the measurement range to 4 g.
// - With per-axis thresholds on, X uses the shared field and Y is built from the two Y registers.
// - With per-axis thresholds on, Z is built from the low bit and six upper bits of the two Z registers.
// - An event is signalled when enabled axes, one alone or hopping between them, stay beyond threshold for the debounce duration.
// - The debounce count register gives the minimum count needed to raise the flags.
module tes_core (
  input wire logic clk_i, // 200 MHz clock
  input wire logic rst_i, // synchronous reset, high
  input wire logic wb_cyc_i, // bus cycle
  input wire logic wb_stb_i, // bus strobe
  input wire logic wb_we_i, // write enable
  input wire logic [9:0] wb_adr_i, // byte address
  input wire logic [3:0] wb_sel_i, // byte lanes
  input wire logic [31:0] wb_dat_i, // write data
  output logic [31:0] wb_dat_o, // read data
  output logic wb_ack_o, // acknowledge
  input wire tes_pkg::tes_sample_s sample_i, // filtered sample
  output logic irq_o // level interrupt
);
  import tes_pkg::*;

  // ----------------------------------------------------------------------
  // scaling
  // ----------------------------------------------------------------------
  // threshold step in 8 g counts, truncated (64 counts, 62.5 mg)
  localparam int unsigned TH_STEP = `TES_THS_MG_PER_LSB * `TES_CNT_PER_G_8G / 1000;

  // over-threshold test of one axis on the 8 g scale
  // trade-off: a whole-count step keeps the compare a shift, at half a milli-g per step
  // limitation: 2 g data drops its two low bits on the way to the 8 g scale
  function automatic logic axis_over(
    input logic signed [13:0] a,
    input tes_range_e rng,
    input logic [6:0] th
  );
    logic signed [13:0] s8;
    logic [14:0] mag;
    logic [14:0] lim;
    s8 = (rng == TES_RANGE_2G) ? (a >>> 2) : (rng == TES_RANGE_4G) ? (a >>> 1) : a;
    mag = s8[13] ? 15'(-$signed({s8[13], s8})) : {1'b0, s8};
    lim = 15'(th * TH_STEP);
    return mag > lim;
  endfunction

  // ----------------------------------------------------------------------
  // state and decode
  // ----------------------------------------------------------------------
  tes_state_s s;
  tes_state_s n;
  logic [7:0] idx;
  logic req;
  logic wr;
  logic read_src;
  logic [2:0] en;
  logic [2:0] over;
  logic [2:0] sgn;
  logic cond;
  logic fire;
  logic hold;
  logic [7:0] dbc_nx;
  tes_range_e range_eff;
  logic [6:0] thx;
  logic [6:0] thy;
  logic [6:0] thz;
  logic [2:0] fbase;
  logic [2:0] pbase;

  // bus decode: one wait state, ack drops the cycle after it was given
  assign idx = wb_adr_i[9:2];
  assign req = wb_cyc_i & wb_stb_i & ~s.ack;
  assign wr = req & wb_we_i & wb_sel_i[0];
  assign read_src = req & ~wb_we_i & (idx == `TES_IDX_SRC);

  // axis enables: cfg bits 3..1 hold Z, Y, X
  assign en = {s.cfg[3], s.cfg[2], s.cfg[1]};
  assign hold = s.cfg[4] & (|s.flag);

  // low noise overrides the range select field
  assign range_eff = s.ctrl[1] ? TES_RANGE_4G : tes_range_e'(s.ctrl[3:2]);

  // per-axis thresholds; the X axis always uses the shared field
  assign thx = s.ths[6:0];
  assign thy = s.ctrl[0] ? {s.thy_hi[0], s.thy_lo[7:2]} : s.ths[6:0];
  assign thz = s.ctrl[0] ? {s.thz_hi[0], s.thz_lo[7:2]} : s.ths[6:0];

  // bit order {z, y, x} matches the flag and polarity vectors
  assign over[0] = en[0] & axis_over(sample_i.x, range_eff, thx);
  assign over[1] = en[1] & axis_over(sample_i.y, range_eff, thy);
  assign over[2] = en[2] & axis_over(sample_i.z, range_eff, thz);
  assign sgn = {sample_i.z[13], sample_i.y[13], sample_i.x[13]};
  assign cond = |over;

  // debounce counter next value, evaluated per sample period
  // one counter serves all axes, so motion that hops between axes still adds up
  always_comb
  begin
    dbc_nx = s.dbc;
    if (sample_i.valid)
    begin
      if (cond)
        dbc_nx = (s.dbc == `TES_CNT_MAX) ? s.dbc : s.dbc + 8'h01;
      else if (s.ths[`TES_THS_MODE])
        dbc_nx = 8'h00;
      else if (s.dbc != 8'h00)
        dbc_nx = s.dbc - 8'h01;
    end
  end

  // count zero fires on the first period with the condition
  assign fire = sample_i.valid & cond & (dbc_nx >= s.cnt);

  // ----------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------
  always_comb
  begin
    n = s;
    n.ack = req;
    n.dbc = dbc_nx;
    // a read clears first, so an event in the same cycle survives it
    fbase = read_src ? 3'h0 : s.flag;
    pbase = read_src ? 3'h0 : s.pol;
    n.flag = fbase;
    n.pol = pbase;
    if (fire && (!hold || read_src))
    begin
      n.flag = fbase | over;
      n.pol = (pbase & ~over) | (sgn & over);
    end
    // sticky event bit: a set beats a write-one clear
    n.istat = fire | (s.istat & ~(wr && idx == `TES_IDX_ISTAT && wb_dat_i[0]));
    // writes land at the edge the request is taken, ack follows a cycle later
    if (wr)
    begin
      unique case (idx)
        `TES_IDX_CFG: n.cfg = {3'h0, wb_dat_i[4:0]};
        `TES_IDX_THS: n.ths = wb_dat_i[7:0];
        `TES_IDX_CNT: n.cnt = wb_dat_i[7:0];
        `TES_IDX_CTRL: n.ctrl = {4'h0, wb_dat_i[3:0]};
        `TES_IDX_IMASK: n.imask = wb_dat_i[0];
        `TES_IDX_THY_HI: n.thy_hi = wb_dat_i[7:0];
        `TES_IDX_THY_LO: n.thy_lo = wb_dat_i[7:0];
        `TES_IDX_THZ_HI: n.thz_hi = wb_dat_i[7:0];
        `TES_IDX_THZ_LO: n.thz_lo = wb_dat_i[7:0];
        default: n.cfg = s.cfg; // read-only or unmapped: ignored
      endcase
    end
    // read data shows the value before any read side effect
    n.rdata = 32'h0;
    if (req && !wb_we_i)
    begin
      unique case (idx)
        `TES_IDX_SRC: n.rdata = {25'h0, |s.flag, s.flag[2], s.pol[2],
                                 s.flag[1], s.pol[1], s.flag[0], s.pol[0]};
        `TES_IDX_CFG: n.rdata = {24'h0, s.cfg};
        `TES_IDX_THS: n.rdata = {24'h0, s.ths};
        `TES_IDX_CNT: n.rdata = {24'h0, s.cnt};
        `TES_IDX_CTRL: n.rdata = {24'h0, s.ctrl};
        `TES_IDX_ISTAT: n.rdata = {31'h0, s.istat};
        `TES_IDX_IMASK: n.rdata = {31'h0, s.imask};
        `TES_IDX_THY_HI: n.rdata = {24'h0, s.thy_hi};
        `TES_IDX_THY_LO: n.rdata = {24'h0, s.thy_lo};
        `TES_IDX_THZ_HI: n.rdata = {24'h0, s.thz_hi};
        `TES_IDX_THZ_LO: n.rdata = {24'h0, s.thz_lo};
        default: n.rdata = 32'h0;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      s <= '0;
      s.cfg <= `TES_RST_BYTE;
      s.ths <= `TES_RST_BYTE;
      s.cnt <= `TES_RST_BYTE;
    end
    else
      s <= n;
  end

  // outputs straight from flip-flops, interrupt gated by the mask
  assign wb_dat_o = s.rdata;
  assign wb_ack_o = s.ack;
  assign irq_o = s.istat & s.imask;

  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  property p_ea_summary;
    wb_ack_o && !$past(wb_we_i) && $past(idx) == `TES_IDX_SRC
      |-> wb_dat_o[6] == (wb_dat_o[5] | wb_dat_o[3] | wb_dat_o[1]);
  endproperty
  a_ea_summary: assert property (p_ea_summary) else $error("summary bit disagrees with flags");

  property p_flag_set;
    fire && (!hold || read_src) |=> (s.flag & $past(over)) == $past(over);
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("axis flag not set on event");

  property p_pol_x;
    fire && over[0] && !hold |=> s.pol[0] == $past(sample_i.x[13]);
  endproperty
  a_pol_x: assert property (p_pol_x) else $error("x polarity wrong");

  property p_latch_hold;
    hold && !read_src |=> s.flag == $past(s.flag) && s.pol == $past(s.pol);
  endproperty
  a_latch_hold: assert property (p_latch_hold) else $error("latched flags changed");

  property p_unlatched_update;
    fire && !s.cfg[4] && over[1] |=> s.flag[1] && s.pol[1] == $past(sample_i.y[13]);
  endproperty
  a_unlatched_update: assert property (p_unlatched_update) else $error("flags not updated");

  property p_clear_by_read;
    !read_src |=> (s.flag & $past(s.flag)) == $past(s.flag);
  endproperty
  a_clear_by_read: assert property (p_clear_by_read) else $error("flag dropped without read");

  property p_dec_mode;
    sample_i.valid && !cond && !s.ths[7] && s.dbc != 8'h00 |=> s.dbc == $past(s.dbc) - 8'h01;
  endproperty
  a_dec_mode: assert property (p_dec_mode) else $error("counter did not decrement");

  property p_clr_mode;
    sample_i.valid && !cond && s.ths[7] |=> s.dbc == 8'h00;
  endproperty
  a_clr_mode: assert property (p_clr_mode) else $error("counter did not clear");

  property p_inc_fire;
    sample_i.valid && cond && s.dbc != `TES_CNT_MAX
      |=> s.dbc == $past(s.dbc) + 8'h01 && $past(fire) == (s.dbc >= $past(s.cnt));
  endproperty
  a_inc_fire: assert property (p_inc_fire) else $error("counter or event timing wrong");

  property p_irq_follow;
    fire |=> s.istat ##0 (irq_o == s.imask);
  endproperty
  a_irq_follow: assert property (p_irq_follow) else $error("interrupt status not set");

  c_fire: cover property (fire);
  c_latched_read: cover property (hold ##[1:20] read_src);
  c_fire_on_read: cover property (fire && read_src);
  c_dec_to_zero: cover property (s.dbc == 8'h01 ##1 s.dbc == 8'h00);
  c_per_axis_fire: cover property (fire && s.ctrl[0]);

  // ----------------------------------------------------------------------
  // threshold, range and bus checks, worked out apart from axis_over
  // ----------------------------------------------------------------------
  // a positive x sample on the 8 g scale is over when above 64 counts per step
  property p_x_over_8g;
    en[0] && range_eff == TES_RANGE_8G && !sample_i.x[13]
      |-> over[0] == ({1'b0, sample_i.x} > {2'b00, thx, 6'h00});
  endproperty
  a_x_over_8g: assert property (p_x_over_8g)
    else $error("x compare wrong on the 8 g scale");

  // low noise halves the sample before the compare, whatever the range field holds
  property p_low_noise;
    en[0] && s.ctrl[1] && !sample_i.x[13]
      |-> over[0] == ({2'b00, sample_i.x[13:1]} > {2'b00, thx, 6'h00});
  endproperty
  a_low_noise: assert property (p_low_noise)
    else $error("low noise range not applied");

  // the y threshold comes from the two y registers when per-axis mode is on
  property p_y_own_th;
    en[1] && s.ctrl[0] && range_eff == TES_RANGE_8G && !sample_i.y[13]
      |-> over[1] == ({1'b0, sample_i.y} > {2'b00, s.thy_hi[0], s.thy_lo[7:2], 6'h00});
  endproperty
  a_y_own_th: assert property (p_y_own_th)
    else $error("y threshold not taken from its own registers");

  // the z threshold comes from the two z registers when per-axis mode is on
  property p_z_own_th;
    en[2] && s.ctrl[0] && range_eff == TES_RANGE_8G && !sample_i.z[13]
      |-> over[2] == ({1'b0, sample_i.z} > {2'b00, s.thz_hi[0], s.thz_lo[7:2], 6'h00});
  endproperty
  a_z_own_th: assert property (p_z_own_th)
    else $error("z threshold not taken from its own registers");

  // the event fires exactly when the advanced count reaches the programmed count
  property p_cnt_gate;
    sample_i.valid && cond
      |-> fire == (({1'b0, s.dbc} + 9'h001) >= {1'b0, s.cnt});
  endproperty
  a_cnt_gate: assert property (p_cnt_gate)
    else $error("event fired off the programmed count");

  // a source read with no event in the same cycle leaves nothing behind
  property p_read_clear;
    read_src && !fire |=> s.flag == 3'h0 && s.pol == 3'h0;
  endproperty
  a_read_clear: assert property (p_read_clear)
    else $error("source read did not clear flags");

  // a z event stores the sign of the z sample whenever the flags may move
  property p_pol_z;
    fire && over[2] && (!hold || read_src)
      |=> s.pol[2] == $past(sample_i.z[13]);
  endproperty
  a_pol_z: assert property (p_pol_z)
    else $error("z polarity wrong");

  // writing a one clears the sticky bit unless an event lands in the same cycle
  property p_istat_w1c;
    wr && idx == `TES_IDX_ISTAT && wb_dat_i[0] && !fire |=> !s.istat;
  endproperty
  a_istat_w1c: assert property (p_istat_w1c)
    else $error("interrupt status not cleared by write");

  // every request taken is answered by one ack pulse a cycle later
  property p_ack_once;
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o;
  endproperty
  a_ack_once: assert property (p_ack_once)
    else $error("ack not a single pulse");

endmodule // tes_core

// *** core/tes_regs.svh ***
/*
  Register indices, field positions, reset values and scaling constants
  of the transient status / threshold block.
  Assumes a 32-bit word bus: byte address = 4 * register index.
*/
`ifndef TES_REGS_SVH
`define TES_REGS_SVH

// ----------------------------------------------------------------------
// register indices (byte address is four times the index)
// ----------------------------------------------------------------------
`define TES_IDX_CFG 8'h1d
`define TES_IDX_SRC 8'h1e
`define TES_IDX_THS 8'h1f
`define TES_IDX_CNT 8'h20
`define TES_IDX_CTRL 8'h40
`define TES_IDX_ISTAT 8'h41
`define TES_IDX_IMASK 8'h42
`define TES_IDX_THY_HI 8'h75
`define TES_IDX_THY_LO 8'h76
`define TES_IDX_THZ_HI 8'h77
`define TES_IDX_THZ_LO 8'h78

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define TES_SRC_EA 6
`define TES_SRC_ZEF 5
`define TES_SRC_ZPOL 4
`define TES_SRC_YEF 3
`define TES_SRC_YPOL 2
`define TES_SRC_XEF 1
`define TES_SRC_XPOL 0
`define TES_THS_MODE 7

// ----------------------------------------------------------------------
// reset values and scaling
// ----------------------------------------------------------------------
`define TES_RST_BYTE 8'h00
`define TES_THS_MG_PER_LSB 63
`define TES_CNT_PER_G_8G 1024
`define TES_CNT_MAX 8'hff

`endif

// *** core/tes_pkg.sv ***
/*
  Types shared by the transient status / threshold block.
  Assumes tes_regs.svh holds every numeric constant.
*/
package tes_pkg;

  // one output-data-rate sample, already high-pass filtered upstream
  typedef struct packed {
    logic valid;
    logic signed [13:0] x;
    logic signed [13:0] y;
    logic signed [13:0] z;
  } tes_sample_s;

  // full-scale encoding of the range select field
  typedef enum logic [1:0] {
    TES_RANGE_2G = 2'h0,
    TES_RANGE_4G = 2'h1,
    TES_RANGE_8G = 2'h2
  } tes_range_e;

  // complete register and logic state of the block
  typedef struct packed {
    logic [2:0] flag;
    logic [2:0] pol;
    logic [7:0] cfg;
    logic [7:0] ths;
    logic [7:0] cnt;
    logic [7:0] ctrl;
    logic [7:0] thy_hi;
    logic [7:0] thy_lo;
    logic [7:0] thz_hi;
    logic [7:0] thz_lo;
    logic istat;
    logic imask;
    logic [7:0] dbc;
    logic ack;
    logic [31:0] rdata;
  } tes_state_s;

endpackage

// *** sim/tes_host_model.sv ***
/*
  Host model: a classic Wishbone master for tes_core.
  Assumes one go pulse per transfer and the core's clock.
*/
`timescale 1ns/1ps
module tes_host_model (
  input wire logic clk_i, // clock
  input wire logic rst_i, // sync reset
  input wire logic go_i, // start transfer
  input wire logic we_i, // 1 = write
  input wire logic [7:0] idx_i, // register index
  input wire logic [31:0] wdat_i, // write data
  output logic done_o, // completion pulse
  output logic [31:0] rdat_o, // captured read data
  output logic wb_cyc_o, // cycle
  output logic wb_stb_o, // strobe
  output logic wb_we_o, // direction
  output logic [9:0] wb_adr_o, // byte address
  output logic [3:0] wb_sel_o, // byte lanes
  output logic [31:0] wb_dat_o, // write data
  input wire logic [31:0] wb_dat_i, // read data
  input wire logic wb_ack_i // acknowledge
);
  assign wb_sel_o = 4'h1;

  // request held until ack is seen, read data taken at that edge
  always_ff @(posedge clk_i)
  begin
    done_o <= 1'b0;
    if (rst_i)
    begin
      wb_cyc_o <= 1'b0;
      wb_stb_o <= 1'b0;
      wb_we_o <= 1'b0;
      wb_adr_o <= 10'h000;
      wb_dat_o <= 32'h0;
      rdat_o <= 32'h0;
    end
    else if (wb_cyc_o && wb_ack_i)
    begin
      wb_cyc_o <= 1'b0;
      wb_stb_o <= 1'b0;
      wb_dat_o <= ~wb_dat_o; // released data lines carry the complement of the last value
      rdat_o <= wb_dat_i;
      done_o <= 1'b1;
    end
    else if (go_i && !wb_cyc_o)
    begin
      wb_cyc_o <= 1'b1;
      wb_stb_o <= 1'b1;
      wb_we_o <= we_i;
      wb_adr_o <= {idx_i, 2'b00};
      wb_dat_o <= wdat_i;
    end
  end
endmodule // tes_host_model

// *** sim/transient_event_status_threshold_tb_top.sv ***
/*
  Scenario bench for tes_core through the host model.
  Assumes core files and tes_host_model are compiled first.
*/
`timescale 1ns/1ps
`include "tes_regs.svh"
module transient_event_status_threshold_tb_top;
  import tes_pkg::*;
  logic clk_i, rst_i, go, we, done, cyc, stb, hwe, ack, irq;
  logic [7:0] idx;
  logic [31:0] wd, rdat, dw, dr;
  logic [9:0] adr;
  logic [3:0] sel;
  tes_sample_s smp;
  int error_cnt = 0;
  int tests_run = 0;

  initial
  begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end

  tes_host_model u_tes_host_model (.clk_i(clk_i), .rst_i(rst_i), .go_i(go), .we_i(we), .idx_i(idx),
    .wdat_i(wd), .done_o(done), .rdat_o(rdat), .wb_cyc_o(cyc), .wb_stb_o(stb), .wb_we_o(hwe),
    .wb_adr_o(adr), .wb_sel_o(sel), .wb_dat_o(dw), .wb_dat_i(dr), .wb_ack_i(ack));
  tes_core u_tes_core (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(hwe),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dw), .wb_dat_o(dr), .wb_ack_o(ack), .sample_i(smp),
    .irq_o(irq));

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic results;
    $display("errors %0d, checks %0d", error_cnt, tests_run);
    if (error_cnt == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e)
    begin
      error_cnt++;
      $display("wrong value at %0t: reg %h expected %h", $time, g, e);
    end
  endtask

  task automatic chk_irq(input logic e);
    tests_run++;
    if (irq !== e)
    begin
      error_cnt++;
      $display("wrong value at %0t: irq %b", $time, irq);
    end
  endtask

  // bounded wait for the model's completion pulse
  task automatic bus(input logic w, input logic [7:0] i, input logic [31:0] d);
    int n;
    @(posedge clk_i);
    go <= 1'b1;
    we <= w;
    idx <= i;
    wd <= d;
    @(posedge clk_i);
    go <= 1'b0;
    for (n = 0; n < 20 && done !== 1'b1; n++)
      @(posedge clk_i);
    if (done !== 1'b1)
    begin
      error_cnt++;
      results();
    end
  endtask

  task automatic wr(input logic [7:0] i, input logic [7:0] d);
    bus(1'b1, i, {24'h0, d});
  endtask

  task automatic rdc(input logic [7:0] i, input logic [7:0] e);
    bus(1'b0, i, 32'h0);
    chk(rdat, {24'h0, e});
  endtask

  // one valid pulse carries one sample period
  task automatic samp(input int x, input int y, input int z);
    @(posedge clk_i);
    smp <= {1'b1, 14'(x), 14'(y), 14'(z)};
    @(posedge clk_i);
    smp.valid <= 1'b0;
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_regs;
    rdc(`TES_IDX_SRC, 8'h00);
    rdc(`TES_IDX_THS, 8'h00);
    rdc(8'h33, 8'h00);
    wr(`TES_IDX_THS, 8'h55);
    rdc(`TES_IDX_THS, 8'h55);
    chk_irq(1'b0);
  endtask

  // threshold 2 steps is 128 counts on the 8 g scale, strictly over
  task automatic t_thresh;
    wr(`TES_IDX_CTRL, 8'h08);
    wr(`TES_IDX_CFG, 8'h0e);
    wr(`TES_IDX_THS, 8'h02);
    wr(`TES_IDX_CNT, 8'h00);
    samp(128, 0, 0);
    rdc(`TES_IDX_SRC, 8'h00);
    samp(129, 0, 0);
    rdc(`TES_IDX_SRC, 8'h42);
    rdc(`TES_IDX_SRC, 8'h00);
    samp(0, -200, 200);
    rdc(`TES_IDX_SRC, 8'h6c);
    samp(-200, 0, -200);
    rdc(`TES_IDX_SRC, 8'h73);
  endtask

  task automatic t_debounce;
    wr(`TES_IDX_THS, 8'h82);
    wr(`TES_IDX_CNT, 8'h03);
    samp(0, 0, 0);
    samp(200, 0, 0);
    samp(200, 0, 0);
    samp(0, 0, 0);
    samp(200, 0, 0);
    samp(200, 0, 0);
    rdc(`TES_IDX_SRC, 8'h00);
    samp(200, 0, 0);
    rdc(`TES_IDX_SRC, 8'h42);
    wr(`TES_IDX_THS, 8'h02);
    repeat (4) samp(0, 0, 0);
    samp(200, 0, 0);
    samp(200, 0, 0);
    samp(0, 0, 0);
    samp(200, 0, 0);
    rdc(`TES_IDX_SRC, 8'h00);
    samp(200, 0, 0);
    rdc(`TES_IDX_SRC, 8'h42);
  endtask

  task automatic t_latch;
    wr(`TES_IDX_CNT, 8'h00);
    wr(`TES_IDX_CFG, 8'h12);
    samp(200, 0, 0);
    samp(-200, 0, 0);
    rdc(`TES_IDX_SRC, 8'h42);
    wr(`TES_IDX_CFG, 8'h02);
    samp(200, 0, 0);
    samp(-200, 0, 0);
    rdc(`TES_IDX_SRC, 8'h43);
  endtask

  // Y threshold 64 steps, Z threshold 1 step
  task automatic t_axis;
    wr(`TES_IDX_CFG, 8'h0e);
    wr(`TES_IDX_THY_HI, 8'h01);
    wr(`TES_IDX_THY_LO, 8'h00);
    wr(`TES_IDX_THZ_HI, 8'h00);
    wr(`TES_IDX_THZ_LO, 8'h04);
    wr(`TES_IDX_CTRL, 8'h09);
    samp(0, 3000, 100);
    rdc(`TES_IDX_SRC, 8'h60);
    samp(129, 4097, 0);
    rdc(`TES_IDX_SRC, 8'h4a);
  endtask

  task automatic t_range;
    wr(`TES_IDX_CTRL, 8'h00);
    samp(500, 0, 0);
    rdc(`TES_IDX_SRC, 8'h00);
    samp(600, 0, 0);
    rdc(`TES_IDX_SRC, 8'h42);
    wr(`TES_IDX_CTRL, 8'h02);
    samp(300, 0, 0);
    rdc(`TES_IDX_SRC, 8'h42);
    wr(`TES_IDX_CTRL, 8'h04);
    samp(-200, 0, 0);
    rdc(`TES_IDX_SRC, 8'h00);
    samp(-257, 0, 0);
    rdc(`TES_IDX_SRC, 8'h43);
  endtask

  task automatic t_irq;
    wr(`TES_IDX_ISTAT, 8'h01);
    rdc(`TES_IDX_ISTAT, 8'h00);
    samp(300, 0, 0);
    chk_irq(1'b0);
    rdc(`TES_IDX_ISTAT, 8'h01);
    wr(`TES_IDX_IMASK, 8'h01);
    chk_irq(1'b1);
    wr(`TES_IDX_ISTAT, 8'h01);
    chk_irq(1'b0);
    rdc(`TES_IDX_SRC, 8'h42);
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    rst_i = 1'b1;
    go = 1'b0;
    we = 1'b0;
    idx = 8'h00;
    wd = 32'h0;
    smp = '0;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    t_regs();
    t_thresh();
    t_debounce();
    t_latch();
    t_axis();
    t_range();
    t_irq();
    results();
  end
endmodule // transient_event_status_threshold_tb_top
